// ===== hw/ccr_pkg.sv
// Constants of the charger control register bank: offsets, reset values,
// write and restore masks, field positions and timing counts.
// Assumes an 8-bit register port fed by the serial host interface engine.
package ccr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_REV_V_LO = 8'h0c;
    localparam logic [7:0] ADDR_REV_V_HI = 8'h0d;
    localparam logic [7:0] ADDR_PRECHG = 8'h0e;
    localparam logic [7:0] ADDR_TERM = 8'h0f;
    localparam logic [7:0] ADDR_PTC = 8'h10;
    localparam logic [7:0] ADDR_TMR = 8'h11;
    localparam logic [7:0] ADDR_CC1 = 8'h12;
    localparam logic [7:0] ADDR_CC2 = 8'h13;
    localparam logic [7:0] ADDR_CC3 = 8'h14;
    localparam logic [7:0] ADDR_CC4 = 8'h15;
    localparam logic [7:0] ADDR_CONV = 8'h16;

    // ------------------------------------------------------------
    // Reset values and clamp limits
    // ------------------------------------------------------------
    localparam logic [10:0] RST_REV_V = 11'h0fa;
    localparam logic [10:0] REV_V_MIN = 11'h0af;
    localparam logic [10:0] REV_V_MAX = 11'h6a4;
    localparam logic [5:0] RST_PRECHG = 6'h05;
    localparam logic [5:0] RST_TERM = 6'h05;
    localparam logic [5:0] CUR_MIN = 6'h01;
    localparam logic [5:0] CUR_MAX = 6'h1f;
    localparam logic [7:0] RST_PTC = 8'h2f;
    localparam logic [7:0] RST_TMR = 8'h1d;
    localparam logic [7:0] RST_CC1 = 8'h80;
    localparam logic [7:0] RST_CC2 = 8'ha0;
    localparam logic [7:0] RST_CC3 = 8'h28;
    localparam logic [7:0] RST_CC4 = 8'h00;
    localparam logic [7:0] RST_CONV = 8'he1;

    // ------------------------------------------------------------
    // Masks: writable bits, watchdog-restored bits, register-reset bits
    // ------------------------------------------------------------
    localparam logic [7:0] WMASK_CC4 = 8'h0b;
    localparam logic [7:0] WDM_TMR = 8'h08;
    localparam logic [7:0] WDM_CC1 = 8'h14;
    localparam logic [7:0] WDM_CC2 = 8'h4b;
    localparam logic [7:0] WDM_CC3 = 8'h34;
    localparam logic [7:0] RRM_CC1 = 8'hfd;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PTC_REG_RST = 7;
    localparam int PTC_STAT_DIS = 6;
    localparam int PTC_RECHG = 4;
    localparam int PTC_TERM_EN = 3;
    localparam int PTC_EXIT = 1;
    localparam int PTC_PRE_EN = 0;
    localparam int TMR_TOPOFF = 6;
    localparam int TMR_WD = 4;
    localparam int TMR_SAFE_EN = 3;
    localparam int TMR_FAST = 1;
    localparam int TMR_DOUBLE = 0;
    localparam int CC1_REV_I = 6;
    localparam int CC1_BAT_SNS = 5;
    localparam int CC1_BYPASS = 4;
    localparam int CC1_EXT_PATH = 3;
    localparam int CC1_KICK = 2;
    localparam int CC1_STOP_WD = 1;
    localparam int CC1_PRE_TMR = 0;
    localparam int CC2_AUTO_DSCHG = 7;
    localparam int CC2_FORCE_SYS = 6;
    localparam int CC2_CHG_EN = 5;
    localparam int CC2_HIZ = 4;
    localparam int CC2_FORCE_VIN = 3;
    localparam int CC2_IN_SNS = 2;
    localparam int CC2_SOURCE = 1;
    localparam int CC2_BACKUP = 0;
    localparam int CC3_BACKUP_RATIO = 6;
    localparam int CC3_EXT_ILIM = 5;
    localparam int CC3_BAT_OFF = 4;
    localparam int CC3_BAT_DET = 3;
    localparam int CC3_ABS_VLIM = 2;
    localparam int CC3_OPT_FORCE = 1;
    localparam int CC3_OPT_EN = 0;
    localparam int CC4_FAST_RESP = 3;
    localparam int CC4_DET_SET = 0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned SECOND_S = 1;
    localparam int unsigned SECOND_CYCLES = CLK_HZ * SECOND_S;
    localparam int TICK_W = 27;
    localparam logic [7:0] WD_PERIOD_1_S = 8'd40;
    localparam logic [7:0] WD_PERIOD_2_S = 8'd80;
    localparam logic [7:0] WD_PERIOD_3_S = 8'd160;

endpackage

// ===== hw/ccr_register_bank.sv
// Charger control register bank: control registers, register reset,
// host watchdog and safety timer time base.
// Assumes a serial host interface engine that delivers one decoded byte
// access per REG_WR or REG_RD pulse, synchronous to CLK_SYS.
`timescale 1ns/100ps
`default_nettype none

module ccr_register_bank
    import ccr_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = SECOND_CYCLES
)
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic INPUT_VALID,
    input wire logic REGULATION_ACTIVE,
    input wire logic OVP_FORWARD,
    input wire logic OVP_REVERSE,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    output logic HOST_MODE,
    output logic WD_EXPIRED,
    output logic SAFETY_TICK,
    output logic OPTIMIZER_START,
    output logic [10:0] REVERSE_OUTPUT_VOLTAGE_TARGET,
    output logic [5:0] PRECHARGE_CURRENT_LIMIT,
    output logic [5:0] TERMINATION_CURRENT_THRESHOLD,
    output logic TERMINATION_ENABLE,
    output logic PRECHARGE_ENABLE,
    output logic STATUS_PIN_DISABLE,
    output logic [1:0] RECHARGE_THRESHOLD_SELECT,
    output logic [1:0] PRECHARGE_EXIT_THRESHOLD,
    output logic [1:0] TOPOFF_TIMER_SELECT,
    output logic SAFETY_TIMER_ENABLE,
    output logic [1:0] FAST_CHARGE_TIMER_SELECT,
    output logic PRECHARGE_TIMER_SELECT,
    output logic [1:0] REVERSE_BATTERY_CURRENT_LIMIT,
    output logic BATTERY_SENSE_RESISTOR_SELECT,
    output logic INPUT_SENSE_RESISTOR_SELECT,
    output logic INTERNAL_BYPASS_ENABLE,
    output logic EXTERNAL_BYPASS_ENABLE,
    output logic CHARGE_ENABLE,
    output logic HIGH_IMPEDANCE_ENABLE,
    output logic SOURCE_MODE_ENABLE,
    output logic BACKUP_ENABLE,
    output logic [1:0] BACKUP_TRIGGER_RATIO,
    output logic SYSTEM_DISCHARGE_LOAD,
    output logic INPUT_DISCHARGE_LOAD,
    output logic BATTERY_DETECTION_ENABLE,
    output logic [1:0] BATTERY_DETECTION_SETPOINT,
    output logic OPTIMIZER_ENABLE,
    output logic EXT_CURRENT_LIMIT_ENABLE,
    output logic BATTERY_SWITCH_OFF,
    output logic ABSOLUTE_INPUT_LIMIT,
    output logic FAST_REVERSE_RESPONSE,
    output logic [7:0] CONVERTER_CONTROL
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // The prescaler must fit its counter and must divide by at least two
    if (TICK_CYCLES < 2 || TICK_CYCLES > (2 ** TICK_W))
    begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [10:0] rev_v;
        logic [7:0] rev_lo_hold;
        logic [5:0] prechg;
        logic [5:0] term;
        logic [7:0] ptc;
        logic [7:0] tmr;
        logic [7:0] cc1;
        logic [7:0] cc2;
        logic [7:0] cc3;
        logic [7:0] cc4;
        logic [7:0] conv;
        logic host_mode;
        logic wd_expired;
        logic [7:0] wd_sec;
        logic [TICK_W-1:0] tick_cnt;
        logic half;
        logic safety_tick;
        logic [7:0] rdata;
        logic rvalid;
    } ccr_state_t;

    localparam ccr_state_t STATE_RST = '{
        rev_v: RST_REV_V,
        prechg: RST_PRECHG,
        term: RST_TERM,
        ptc: RST_PTC,
        tmr: RST_TMR,
        cc1: RST_CC1,
        cc2: RST_CC2,
        cc3: RST_CC3,
        cc4: RST_CC4,
        conv: RST_CONV,
        wd_expired: 1'b1,
        default: '0
    };

    ccr_state_t s;
    ccr_state_t next_s;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Watchdog period in seconds; zero means the watchdog is off
    function automatic logic [7:0] wd_limit(input logic [1:0] sel);
        return (sel == 2'b01) ? WD_PERIOD_1_S : (sel == 2'b10) ? WD_PERIOD_2_S :
            (sel == 2'b11) ? WD_PERIOD_3_S : 8'h00;
    endfunction

    // Current codes saturate rather than wrap so a bad write stays safe
    function automatic logic [5:0] clamp_cur(input logic [5:0] code);
        return (code < CUR_MIN) ? CUR_MIN : (code > CUR_MAX) ? CUR_MAX : code;
    endfunction

    function automatic logic [10:0] clamp_rev(input logic [10:0] code);
        return (code < REV_V_MIN) ? REV_V_MIN : (code > REV_V_MAX) ? REV_V_MAX : code;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [7:0] wd_lim;
    logic sec_tick;
    logic [10:0] rev_cand;
    logic [7:0] cc3_w;

    // One process orders timers, expiry, host write, register reset, bypass effects, then read data
    always_comb
    begin
        next_s = s;
        next_s.safety_tick = 1'b0;
        next_s.rvalid = 1'b0;
        next_s.cc1[CC1_KICK] = 1'b0; // Kick reads back 1 for one cycle
        next_s.cc3[CC3_OPT_FORCE] = 1'b0; // Start pulse lasts one cycle
        wd_lim = wd_limit(s.tmr[TMR_WD +: 2]);
        rev_cand = {REG_WDATA[6:0], s.rev_lo_hold[7:4]};
        cc3_w = REG_WDATA;

        // Shared one-second prescaler; a watchdog restart re-phases it,
        // trading up to a second of safety timer jitter for one counter
        sec_tick = (s.tick_cnt == TICK_W'(TICK_CYCLES - 1));
        next_s.tick_cnt = sec_tick ? '0 : s.tick_cnt + 1'b1;

        // Safety time base, halved while regulating with doubling on
        if (sec_tick && s.tmr[TMR_SAFE_EN])
        begin
            next_s.half = s.tmr[TMR_DOUBLE] & REGULATION_ACTIVE & ~s.half;
            next_s.safety_tick = ~next_s.half;
        end

        // Host watchdog counts whole seconds in host mode only
        if (s.host_mode && wd_lim != 8'h00 && sec_tick)
        begin
            next_s.wd_sec = s.wd_sec + 8'd1;
            if (s.wd_sec + 8'd1 == wd_lim)
            begin
                next_s.host_mode = 1'b0;
                next_s.wd_expired = 1'b1;
                next_s.wd_sec = 8'h00;
                next_s.tmr = (s.tmr & ~WDM_TMR) | (RST_TMR & WDM_TMR);
                next_s.cc1 = (next_s.cc1 & ~WDM_CC1) | (RST_CC1 & WDM_CC1);
                next_s.cc2 = (s.cc2 & ~WDM_CC2) | (RST_CC2 & WDM_CC2);
                next_s.cc3 = (next_s.cc3 & ~WDM_CC3) | (RST_CC3 & WDM_CC3);
                next_s.cc2[CC2_CHG_EN] = next_s.cc2[CC2_CHG_EN] & ~s.cc1[CC1_STOP_WD];
            end
        end

        // Host write: enters host mode, restarts a stopped watchdog
        if (REG_WR)
        begin
            if (!next_s.host_mode || next_s.wd_expired) // Also after a same-cycle expiry
            begin
                next_s.wd_sec = 8'h00;
                next_s.tick_cnt = '0;
                next_s.wd_expired = 1'b0;
            end
            next_s.host_mode = 1'b1;
            unique case (REG_ADDR)
                ADDR_REV_V_LO: next_s.rev_lo_hold = REG_WDATA;
                ADDR_REV_V_HI: next_s.rev_v = clamp_rev(rev_cand);
                ADDR_PRECHG: next_s.prechg = clamp_cur(REG_WDATA[5:0]);
                ADDR_TERM: next_s.term = clamp_cur(REG_WDATA[5:0]);
                ADDR_PTC: next_s.ptc = REG_WDATA;
                ADDR_TMR: next_s.tmr = REG_WDATA;
                ADDR_CC1:
                begin
                    next_s.cc1 = REG_WDATA;
                    if (REG_WDATA[CC1_KICK])
                    begin
                        next_s.wd_sec = 8'h00;
                        next_s.tick_cnt = '0;
                    end
                end
                ADDR_CC2:
                begin
                    next_s.cc2 = REG_WDATA;
                    if (!INPUT_VALID)
                    begin
                        next_s.cc2[CC2_BACKUP] = s.cc2[CC2_BACKUP];
                    end
                end
                ADDR_CC3:
                begin
                    // Force start is set-only and needs the optimizer enabled
                    cc3_w[CC3_OPT_FORCE] = REG_WDATA[CC3_OPT_FORCE] & REG_WDATA[CC3_OPT_EN];
                    next_s.cc3 = cc3_w;
                end
                ADDR_CC4: next_s.cc4 = REG_WDATA & WMASK_CC4;
                ADDR_CONV: next_s.conv = REG_WDATA;
                default: next_s.host_mode = 1'b1;
            endcase
        end

        // Register reset lands a cycle after its write and beats any write in that cycle but one to the rev_lo_hold byte
        if (s.ptc[PTC_REG_RST])
        begin
            next_s.rev_v = RST_REV_V;
            next_s.prechg = RST_PRECHG;
            next_s.term = RST_TERM;
            next_s.ptc = RST_PTC;
            next_s.tmr = RST_TMR;
            next_s.cc1 = (RST_CC1 & RRM_CC1) | (s.cc1 & ~RRM_CC1);
            next_s.cc2 = RST_CC2;
            next_s.cc3 = RST_CC3; // Also aborts a pending forced start
            next_s.cc4 = RST_CC4;
            next_s.conv = RST_CONV;
            next_s.wd_sec = 8'h00;
            next_s.tick_cnt = '0;
        end

        // Bypass drops when HIZ rises or source mode falls
        if ((next_s.cc2[CC2_HIZ] && !s.cc2[CC2_HIZ]) ||
            (!next_s.cc2[CC2_SOURCE] && s.cc2[CC2_SOURCE]))
        begin
            next_s.cc1[CC1_BYPASS] = 1'b0;
        end

        // Read data, registered; reserved bits and unmapped offsets give 0
        if (REG_RD)
        begin
            next_s.rvalid = 1'b1;
            unique case (REG_ADDR)
                ADDR_REV_V_LO: next_s.rdata = {s.rev_v[3:0], 4'h0};
                ADDR_REV_V_HI: next_s.rdata = {1'b0, s.rev_v[10:4]};
                ADDR_PRECHG: next_s.rdata = {2'b00, s.prechg};
                ADDR_TERM: next_s.rdata = {2'b00, s.term};
                ADDR_PTC: next_s.rdata = s.ptc;
                ADDR_TMR: next_s.rdata = s.tmr;
                ADDR_CC1: next_s.rdata = s.cc1;
                ADDR_CC2: next_s.rdata = s.cc2;
                ADDR_CC3: next_s.rdata = s.cc3;
                ADDR_CC4: next_s.rdata = s.cc4 & WMASK_CC4;
                ADDR_CONV: next_s.rdata = s.conv;
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Clock enable freezes every field, the timers included
    always_ff @(posedge CLK_SYS or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s <= STATE_RST;
        end
        else if (CE)
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Bus answer and status
    assign REG_RDATA = s.rdata;
    assign REG_RVALID = s.rvalid;
    assign HOST_MODE = s.host_mode;
    assign WD_EXPIRED = s.wd_expired;
    assign SAFETY_TICK = s.safety_tick;
    assign OPTIMIZER_START = s.cc3[CC3_OPT_FORCE];

    // Charge setpoints, thresholds and timers
    assign REVERSE_OUTPUT_VOLTAGE_TARGET = s.rev_v;
    assign PRECHARGE_CURRENT_LIMIT = s.prechg;
    assign TERMINATION_CURRENT_THRESHOLD = s.term;
    assign TERMINATION_ENABLE = s.ptc[PTC_TERM_EN];
    assign PRECHARGE_ENABLE = s.ptc[PTC_PRE_EN];
    assign STATUS_PIN_DISABLE = s.ptc[PTC_STAT_DIS];
    assign RECHARGE_THRESHOLD_SELECT = s.ptc[PTC_RECHG +: 2];
    assign PRECHARGE_EXIT_THRESHOLD = s.ptc[PTC_EXIT +: 2];
    assign TOPOFF_TIMER_SELECT = s.tmr[TMR_TOPOFF +: 2];
    assign SAFETY_TIMER_ENABLE = s.tmr[TMR_SAFE_EN];
    assign FAST_CHARGE_TIMER_SELECT = s.tmr[TMR_FAST +: 2];
    assign PRECHARGE_TIMER_SELECT = s.cc1[CC1_PRE_TMR];

    // Power path, detection and converter settings; force discharge bits ignore auto mode
    assign REVERSE_BATTERY_CURRENT_LIMIT = s.cc1[CC1_REV_I +: 2];
    assign BATTERY_SENSE_RESISTOR_SELECT = s.cc1[CC1_BAT_SNS];
    assign INPUT_SENSE_RESISTOR_SELECT = s.cc2[CC2_IN_SNS];
    assign EXTERNAL_BYPASS_ENABLE = s.cc1[CC1_BYPASS] & s.cc1[CC1_EXT_PATH];
    assign INTERNAL_BYPASS_ENABLE = s.cc1[CC1_BYPASS] & ~s.cc1[CC1_EXT_PATH];
    assign CHARGE_ENABLE = s.cc2[CC2_CHG_EN];
    assign HIGH_IMPEDANCE_ENABLE = s.cc2[CC2_HIZ];
    assign SOURCE_MODE_ENABLE = s.cc2[CC2_SOURCE];
    assign BACKUP_ENABLE = s.cc2[CC2_BACKUP];
    assign BACKUP_TRIGGER_RATIO = s.cc3[CC3_BACKUP_RATIO +: 2];
    assign SYSTEM_DISCHARGE_LOAD = (s.cc2[CC2_AUTO_DSCHG] & OVP_FORWARD) |
                                   s.cc2[CC2_FORCE_SYS];
    assign INPUT_DISCHARGE_LOAD = (s.cc2[CC2_AUTO_DSCHG] & OVP_REVERSE) |
                                  s.cc2[CC2_FORCE_VIN];
    assign BATTERY_DETECTION_ENABLE = s.cc3[CC3_BAT_DET];
    assign BATTERY_DETECTION_SETPOINT = s.cc4[CC4_DET_SET +: 2];
    assign OPTIMIZER_ENABLE = s.cc3[CC3_OPT_EN];
    assign EXT_CURRENT_LIMIT_ENABLE = s.cc3[CC3_EXT_ILIM];
    assign BATTERY_SWITCH_OFF = s.cc3[CC3_BAT_OFF];
    assign ABSOLUTE_INPUT_LIMIT = s.cc3[CC3_ABS_VLIM];
    assign FAST_REVERSE_RESPONSE = s.cc4[CC4_FAST_RESP];
    assign CONVERTER_CONTROL = s.conv;

endmodule

`default_nettype wire

// ===== test/ccr_register_bank_props.sv
// Port checker for the charger control register bank.
// Bound to the bank from the bench top; sees only the bank's ports.
`timescale 1ns/100ps
`default_nettype none
module ccr_register_bank_props
(
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic REG_RVALID,
    input wire logic HOST_MODE,
    input wire logic WD_EXPIRED,
    input wire logic [5:0] PRECHARGE_CURRENT_LIMIT,
    input wire logic [10:0] REVERSE_OUTPUT_VOLTAGE_TARGET,
    input wire logic SOURCE_MODE_ENABLE,
    input wire logic INTERNAL_BYPASS_ENABLE,
    input wire logic EXTERNAL_BYPASS_ENABLE,
    input wire logic BACKUP_ENABLE,
    input wire logic INPUT_VALID,
    input wire logic OPTIMIZER_START,
    input wire logic OPTIMIZER_ENABLE
);
    // ----------------------------------------
    // Relations held at the ports
    // ----------------------------------------
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    chk_write_host_mode: assert property (CE && REG_WR |=> HOST_MODE && !WD_EXPIRED)
        else $error("write did not enter host mode");
    chk_read_answer: assert property (CE && REG_RD |=> REG_RVALID)
        else $error("read not answered");
    chk_precharge_clamp: assert property (PRECHARGE_CURRENT_LIMIT inside {[6'h01:6'h1f]})
        else $error("precharge current out of range");
    chk_reverse_clamp: assert property (REVERSE_OUTPUT_VOLTAGE_TARGET inside {[11'h0af:11'h6a4]})
        else $error("reverse target out of range");
    chk_bypass_on_source: assert property ($fell(SOURCE_MODE_ENABLE) |-> ##[0:1]
        !(INTERNAL_BYPASS_ENABLE || EXTERNAL_BYPASS_ENABLE)) else $error("bypass kept");
    chk_bypass_one_path: assert property (!(INTERNAL_BYPASS_ENABLE && EXTERNAL_BYPASS_ENABLE))
        else $error("both bypass paths on");
    chk_backup_needs_input: assert property (!BACKUP_ENABLE && !INPUT_VALID |=> !BACKUP_ENABLE)
        else $error("backup set without input");
    chk_optimizer_gate: assert property (OPTIMIZER_START |-> OPTIMIZER_ENABLE)
        else $error("optimizer started while disabled");
    chk_expired_default: assert property (WD_EXPIRED |-> !HOST_MODE)
        else $error("host mode after expiry");
    // Main scenarios reached
    cover property (OPTIMIZER_START);
    cover property ($rose(WD_EXPIRED));
    cover property ($fell(SOURCE_MODE_ENABLE));
endmodule
`default_nettype wire

// ===== test/ccr_host_model.sv
// Host side of the byte register port, behind the serial engine.
// Expected read bytes are queued here for the bench monitor.
`timescale 1ns/100ps
`default_nettype none
module ccr_host_model
(
    input wire logic clk_sys,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    logic [7:0] exp_q[$];
    // -----------------------------
    // Byte transfers
    // -----------------------------
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    // A released data bus shows the inverse so a stale byte never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys);
        {reg_wr, reg_wdata} <= {1'b0, ~d};
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== test/tb_ccr_register_bank.sv
// Self-checking bench for the charger control register bank.
// Host model drives the port; a monitor checks read bytes in order.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb_ccr_register_bank;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic input_valid = 1'b0;
    logic ovp_fwd = 1'b0;
    logic ovp_rev = 1'b0;
    logic ce = 1'b1;
    logic reg_act = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid, wd_expired, sys_load, vin_load, safety_tick;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, exp_b;
    logic [7:0] dflt [11] = '{8'ha0, 8'h0f, 8'h05, 8'h05, 8'h2f, 8'h1d, 8'h80, 8'ha0,
        8'h28, 8'h00, 8'he1};
    int fail_count = 0;
    int n_compared = 0;
    int i;
    int n;
    // -----------------------------
    // Clock, design, host
    // -----------------------------
    always #5 clk_sys = ~clk_sys;
    // Short second so a 40 s watchdog lapses in 800 cycles
    ccr_register_bank #(.TICK_CYCLES(20)) dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .INPUT_VALID(input_valid), .REGULATION_ACTIVE(reg_act), .OVP_FORWARD(ovp_fwd),
        .OVP_REVERSE(ovp_rev), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .HOST_MODE(),
        .WD_EXPIRED(wd_expired), .SAFETY_TICK(safety_tick), .OPTIMIZER_START(),
        .REVERSE_OUTPUT_VOLTAGE_TARGET(), .PRECHARGE_CURRENT_LIMIT(),
        .TERMINATION_CURRENT_THRESHOLD(), .TERMINATION_ENABLE(), .PRECHARGE_ENABLE(),
        .STATUS_PIN_DISABLE(), .RECHARGE_THRESHOLD_SELECT(), .PRECHARGE_EXIT_THRESHOLD(),
        .TOPOFF_TIMER_SELECT(), .SAFETY_TIMER_ENABLE(), .FAST_CHARGE_TIMER_SELECT(),
        .PRECHARGE_TIMER_SELECT(), .REVERSE_BATTERY_CURRENT_LIMIT(),
        .BATTERY_SENSE_RESISTOR_SELECT(), .INPUT_SENSE_RESISTOR_SELECT(),
        .INTERNAL_BYPASS_ENABLE(), .EXTERNAL_BYPASS_ENABLE(), .CHARGE_ENABLE(),
        .HIGH_IMPEDANCE_ENABLE(), .SOURCE_MODE_ENABLE(), .BACKUP_ENABLE(),
        .BACKUP_TRIGGER_RATIO(), .SYSTEM_DISCHARGE_LOAD(sys_load),
        .INPUT_DISCHARGE_LOAD(vin_load), .BATTERY_DETECTION_ENABLE(),
        .BATTERY_DETECTION_SETPOINT(), .OPTIMIZER_ENABLE(), .EXT_CURRENT_LIMIT_ENABLE(),
        .BATTERY_SWITCH_OFF(), .ABSOLUTE_INPUT_LIMIT(), .FAST_REVERSE_RESPONSE(),
        .CONVERTER_CONTROL());
    ccr_host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    // Oldest expectation is taken whenever the bank answers a read
    always @(posedge clk_sys)
    begin
        if (reg_rvalid === 1'b1)
        begin
            if (host.exp_q.size() == 0) `CHK(1'b1, 1'b0)
            else
            begin
                // Pop once: the compare macro evaluates its arguments twice
                exp_b = host.exp_q.pop_front();
                `CHK(reg_rdata, exp_b)
            end
        end
    end
    // Six-bit current code as the bank must store it
    function automatic logic [7:0] clamp(input logic [7:0] d);
        return (d[5:0] == 6'h00) ? 8'h01 : (d[5:0] > 6'h1f) ? 8'h1f : {2'b00, d[5:0]};
    endfunction
    task automatic tally_and_finish();
        if (host.exp_q.size() != 0) fail_count++;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // -----------------------------
    // Scenarios
    // -----------------------------
    initial
    begin
        void'($urandom(32'hb751));
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (i = 0; i < 11; i++) host.rd(8'h0c + i[7:0], dflt[i]);
        host.rd(8'h20, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            host.wr(8'h0e, v);
            host.rd(8'h0e, clamp(v));
            host.wr(8'h0f, ~v);
            host.rd(8'h0f, clamp(~v));
        end
        host.wr(8'h0c, 8'h00);
        host.wr(8'h0d, 8'h00);
        host.rd(8'h0c, 8'hf0);
        host.rd(8'h0d, 8'h0a);
        host.wr(8'h0d, 8'h7f);
        host.rd(8'h0c, 8'h40);
        host.wr(8'h15, 8'hff);
        host.rd(8'h15, 8'h0b);
        host.wr(8'h13, 8'ha1);
        host.rd(8'h13, 8'ha0);
        input_valid <= 1'b1;
        host.wr(8'h13, 8'ha1);
        host.rd(8'h13, 8'ha1);
        host.wr(8'h14, 8'h2a);
        host.rd(8'h14, 8'h28);
        host.wr(8'h14, 8'h2b);
        host.rd(8'h14, 8'h29);
        host.wr(8'h12, 8'h84);
        host.rd(8'h12, 8'h80);
        host.wr(8'h14, 8'h21);
        host.wr(8'h13, 8'ha2);
        host.wr(8'h12, 8'h98);
        host.wr(8'h13, 8'ha0);
        host.rd(8'h12, 8'h88);
        {ovp_fwd, ovp_rev} <= 2'b11;
        @(posedge clk_sys);
        `CHK({sys_load, vin_load}, 2'b11)
        {ovp_fwd, ovp_rev} <= 2'b00;
        // A write while the clock enable is low must be lost
        ce <= 1'b0;
        host.wr(8'h16, 8'h00);
        ce <= 1'b1;
        host.rd(8'h16, 8'he1);
        // Safety ticks over 200 cycles: every 2 s while regulating, else every 1 s
        for (i = 0; i < 2; i++)
        begin
            reg_act <= (i == 0);
            @(posedge clk_sys);
            n = 0;
            repeat (200) @(posedge clk_sys) n += int'(safety_tick);
            `CHK(n, (i == 0) ? 5 : 10)
        end
        reg_act <= 1'b0;
        host.wr(8'h10, 8'h80);
        host.rd(8'h0e, 8'h05);
        host.rd(8'h10, 8'h2f);
        host.wr(8'h12, 8'h02);
        host.wr(8'h13, 8'ha4);
        for (i = 0; i < 2000 && wd_expired !== 1'b1; i++) @(posedge clk_sys);
        `CHK(wd_expired, 1'b1)
        if (i == 2000) tally_and_finish();
        host.rd(8'h13, 8'h84);
        repeat (4) @(posedge clk_sys);
        tally_and_finish();
    end
endmodule
bind ccr_register_bank ccr_register_bank_props chk (.CLK_SYS, .RST_N, .CE, .REG_WR, .REG_RD,
    .REG_RVALID, .HOST_MODE, .WD_EXPIRED, .PRECHARGE_CURRENT_LIMIT,
    .REVERSE_OUTPUT_VOLTAGE_TARGET, .SOURCE_MODE_ENABLE, .INTERNAL_BYPASS_ENABLE,
    .EXTERNAL_BYPASS_ENABLE, .BACKUP_ENABLE, .INPUT_VALID, .OPTIMIZER_START, .OPTIMIZER_ENABLE);
`default_nettype wire
